// [hdl/fps_defs.svh]
// Register offsets, field positions and reset values of the fuel sequencer.
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FPS_OFF_CTRL 8'h00
`define FPS_OFF_START 8'h04
`define FPS_OFF_ADV1 8'h08
`define FPS_OFF_ADV2 8'h0C
`define FPS_OFF_TIME0 8'h10
`define FPS_OFF_STATUS 8'h2C
`define FPS_OFF_SW0 8'h30
`define FPS_NUM_TIMES 7

// ----------------------------------------------------------------------
// Time word order starting at the first time offset
// ----------------------------------------------------------------------
`define FPS_T_PRIMARY_LEN 0
`define FPS_T_FIRST_LEN 1
`define FPS_T_SECOND_LEN 2
`define FPS_T_FOURTH_DLY 3
`define FPS_T_FOURTH_LEN 4
`define FPS_T_FIFTH_DLY 5
`define FPS_T_FIFTH_LEN 6

// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define FPS_BIT_PRIMARY 0
`define FPS_BIT_FIRST 1
`define FPS_BIT_SECOND 2
`define FPS_BIT_FOURTH 3
`define FPS_BIT_FIFTH 4
`define FPS_CTRL_W 5
`define FPS_CTRL_RST 5'h00

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define FPS_ST_OUT 0
`define FPS_ST_ACT_LSB 1
`define FPS_ST_KEY 8
`define FPS_ST_CH_LSB 16

// ----------------------------------------------------------------------
// Widths, resets and bus answers
// ----------------------------------------------------------------------
`define FPS_TIME_W 24
`define FPS_TIME_RST 24'h000000
`define FPS_ANGLE_RST 16'h0000
`define FPS_RESP_OKAY 2'h0
`define FPS_RESP_SLVERR 2'h2

`endif

// [hdl/fps_pkg.sv]
// Types shared by the fuel sequencer modules.
package fps_pkg;

  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_WAIT = 3'b010,
    TMR_ON = 3'b100
  } fps_tmr_e;

  typedef logic [23:0] fps_time_t;

endpackage

// [hdl/fps_pulse_timer.sv]
// One pulse timer: optional delay, then a high interval of a set length.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"

module fps_pulse_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire fps_pkg::fps_time_t delay,
  input wire fps_pkg::fps_time_t len,
  output logic active,
  output logic done
);

  fps_pkg::fps_tmr_e state_r;
  fps_pkg::fps_time_t cnt_r;
  logic done_r;

  // --------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------
  // A start seen while busy is ignored, so one pulse runs per trigger.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= fps_pkg::TMR_IDLE;
      cnt_r <= `FPS_TIME_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        state_r <= fps_pkg::TMR_IDLE;
      end else begin
        case (state_r)
          fps_pkg::TMR_IDLE: begin
            if (start && delay != `FPS_TIME_RST) begin
              state_r <= fps_pkg::TMR_WAIT;
              cnt_r <= delay;
            end else if (start && len != `FPS_TIME_RST) begin
              state_r <= fps_pkg::TMR_ON;
              cnt_r <= len;
            end else if (start) begin
              done_r <= 1'b1;
            end
          end
          fps_pkg::TMR_WAIT: begin
            if (cnt_r != 24'h000001) begin
              cnt_r <= cnt_r - 24'h000001;
            end else if (len != `FPS_TIME_RST) begin
              state_r <= fps_pkg::TMR_ON;
              cnt_r <= len;
            end else begin
              state_r <= fps_pkg::TMR_IDLE;
              done_r <= 1'b1;
            end
          end
          fps_pkg::TMR_ON: begin
            if (cnt_r != 24'h000001) begin
              cnt_r <= cnt_r - 24'h000001;
            end else begin
              state_r <= fps_pkg::TMR_IDLE;
              done_r <= 1'b1;
            end
          end
          default: begin
            state_r <= fps_pkg::TMR_IDLE;
          end
        endcase
      end
    end
  end

  assign active = (state_r == fps_pkg::TMR_ON);
  assign done = done_r;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_len_start;
    @(posedge clk) disable iff (!rstn)
    (state_r == fps_pkg::TMR_IDLE && start && !abort &&
     delay == `FPS_TIME_RST && len == 24'h000003)
    |=> active [*3] ##1 !active;
  endproperty
  a_len_start: assert property (p_len_start)
    else $error("pulse length of three cycles not kept");

  property p_last_count;
    @(posedge clk) disable iff (!rstn)
    (active && cnt_r == 24'h000001 && !abort) |=> (!active && done);
  endproperty
  a_last_count: assert property (p_last_count)
    else $error("pulse did not end on its last count");

endmodule
`default_nettype wire

// [hdl/fps_axil_slave.sv]
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"

module fps_axil_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic aw_full_r, w_full_r;

  // --------------------------------------------------------------------
  // Write path
  // --------------------------------------------------------------------
  // Address and data are taken in either order and held until both are in.
  assign wr_en = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPS_RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `FPS_RESP_SLVERR : `FPS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `FPS_RESP_SLVERR : `FPS_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_b_hold;
    @(posedge clk) disable iff (!rstn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before it was taken");

endmodule
`default_nettype wire

// [hdl/fps_sequencer.sv]
// Top of the five-pulse fuel sequencer with its register file.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"

module fps_sequencer #(
  parameter int ANGLE_W = 16,
  parameter int NUM_CH = 4,
  parameter int CH_W = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ANGLE_W-1:0] crank_angle,
  input wire logic unlock_key,
  output logic pulse_train_out,
  output logic channel_switch_strobe,
  output logic [CH_W-1:0] active_channel,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  logic [`FPS_CTRL_W-1:0] ctrl_r;
  logic [ANGLE_W-1:0] start_angle_r;
  logic [ANGLE_W-1:0] adv_r [2];
  fps_pkg::fps_time_t time_r [`FPS_NUM_TIMES];
  logic [ANGLE_W-1:0] switch_angle_r [NUM_CH];
  logic [ANGLE_W-1:0] crank_prev_r;
  logic [CH_W-1:0] ch_r;
  logic out_r, strobe_r;

  logic wr_en, wr_err, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [ANGLE_W-1:0] ang_before(
      input logic [ANGLE_W-1:0] ref_a, input logic [ANGLE_W-1:0] adv);
    return ref_a - adv;
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int words);
    return (a >= base) && ({24'h000000, a} < {24'h000000, base} +
            32'(words * 4));
  endfunction

  fps_axil_slave u_bus (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Status is read-only, so a write to it is answered with an error.
  assign wr_err = !(wr_addr[1:0] == 2'b00 &&
                    (in_range(wr_addr, `FPS_OFF_CTRL, 4 + `FPS_NUM_TIMES) ||
                     in_range(wr_addr, `FPS_OFF_SW0, NUM_CH)));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `FPS_CTRL_RST;
      start_angle_r <= `FPS_ANGLE_RST;
      adv_r[0] <= `FPS_ANGLE_RST;
      adv_r[1] <= `FPS_ANGLE_RST;
      for (int i = 0; i < `FPS_NUM_TIMES; i++) begin
        time_r[i] <= `FPS_TIME_RST;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        switch_angle_r[c] <= `FPS_ANGLE_RST;
      end
    end else if (wr_en && !wr_err) begin
      if (wr_addr == `FPS_OFF_CTRL) begin
        ctrl_r <= `FPS_CTRL_W'(merge(32'(ctrl_r), wr_data, wr_strb));
      end else if (wr_addr == `FPS_OFF_START) begin
        start_angle_r <= ANGLE_W'(merge(32'(start_angle_r), wr_data,
                                        wr_strb));
      end else if (wr_addr == `FPS_OFF_ADV1 || wr_addr == `FPS_OFF_ADV2) begin
        adv_r[wr_addr[2]] <= ANGLE_W'(merge(32'(adv_r[wr_addr[2]]), wr_data,
                                            wr_strb));
      end else if (in_range(wr_addr, `FPS_OFF_TIME0, `FPS_NUM_TIMES)) begin
        // Only the low 24 bits are kept, so larger values wrap from zero.
        time_r[3'(8'(wr_addr - `FPS_OFF_TIME0) >> 2)] <= `FPS_TIME_W'(merge(
          32'(time_r[3'(8'(wr_addr - `FPS_OFF_TIME0) >> 2)]), wr_data,
          wr_strb));
      end else begin
        switch_angle_r[CH_W'(8'(wr_addr - `FPS_OFF_SW0) >> 2)] <= ANGLE_W'(
          merge(32'(switch_angle_r[CH_W'(8'(wr_addr - `FPS_OFF_SW0) >> 2)]),
          wr_data, wr_strb));
      end
    end
  end

  // --------------------------------------------------------------------
  // Pulse scheduling
  // --------------------------------------------------------------------
  // Index 0 first, 1 second, 2 main, 3 fourth, 4 fifth.
  logic [4:0] start, act, done, allow;
  logic crank_step, switch_hit;
  fps_pkg::fps_time_t dly [5];
  fps_pkg::fps_time_t len [5];

  // The crank angle holds for many clocks; acting only when it steps
  // keeps a matched position from firing again while it stands still.
  assign crank_step = (crank_angle != crank_prev_r);
  assign switch_hit = crank_step && crank_angle == switch_angle_r[ch_r];

  assign allow[0] = ctrl_r[`FPS_BIT_PRIMARY] && ctrl_r[`FPS_BIT_FIRST];
  assign allow[1] = ctrl_r[`FPS_BIT_PRIMARY] && ctrl_r[`FPS_BIT_SECOND];
  assign allow[2] = ctrl_r[`FPS_BIT_PRIMARY];
  assign allow[3] = ctrl_r[`FPS_BIT_PRIMARY] && ctrl_r[`FPS_BIT_FOURTH];
  assign allow[4] = allow[3] && ctrl_r[`FPS_BIT_FIFTH];

  assign start[0] = allow[0] && crank_step &&
    crank_angle == ang_before(start_angle_r, adv_r[0]);
  assign start[1] = allow[1] && crank_step &&
    crank_angle == ang_before(start_angle_r, adv_r[1]);
  assign start[2] = allow[2] && crank_step &&
    crank_angle == start_angle_r;
  assign start[3] = allow[3] && done[2];
  assign start[4] = allow[4] && done[3];

  assign dly[0] = `FPS_TIME_RST;
  assign dly[1] = `FPS_TIME_RST;
  assign dly[2] = `FPS_TIME_RST;
  assign dly[3] = time_r[`FPS_T_FOURTH_DLY];
  assign dly[4] = time_r[`FPS_T_FIFTH_DLY];
  assign len[0] = time_r[`FPS_T_FIRST_LEN];
  assign len[1] = time_r[`FPS_T_SECOND_LEN];
  assign len[2] = time_r[`FPS_T_PRIMARY_LEN];
  assign len[3] = time_r[`FPS_T_FOURTH_LEN];
  assign len[4] = time_r[`FPS_T_FIFTH_LEN];

  for (genvar i = 0; i < 5; i++) begin : g_tmr
    fps_pulse_timer u_tmr (
      .clk(clk),
      .rstn(rstn),
      .start(start[i]),
      .abort(switch_hit),
      .delay(dly[i]),
      .len(len[i]),
      .active(act[i]),
      .done(done[i])
    );
  end

  // --------------------------------------------------------------------
  // Channel multiplexing and output
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crank_prev_r <= `FPS_ANGLE_RST;
      ch_r <= '0;
      strobe_r <= 1'b0;
    end else begin
      crank_prev_r <= crank_angle;
      strobe_r <= switch_hit;
      if (switch_hit) begin
        ch_r <= (ch_r == CH_W'(NUM_CH - 1)) ? '0 :
                ch_r + CH_W'(1);
      end
    end
  end

  // Gates are applied again here so clearing one cuts a running pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= unlock_key && |(act & allow);
    end
  end

  assign pulse_train_out = out_r;
  assign channel_switch_strobe = strobe_r;
  assign active_channel = ch_r;

  // --------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------
  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (rd_addr == `FPS_OFF_CTRL) begin
      rd_data = 32'(ctrl_r);
    end else if (rd_addr == `FPS_OFF_START) begin
      rd_data = 32'(start_angle_r);
    end else if (rd_addr == `FPS_OFF_ADV1 || rd_addr == `FPS_OFF_ADV2) begin
      rd_data = 32'(adv_r[rd_addr[2]]);
    end else if (rd_addr[1:0] == 2'b00 &&
                 in_range(rd_addr, `FPS_OFF_TIME0, `FPS_NUM_TIMES)) begin
      rd_data = 32'(time_r[3'(8'(rd_addr - `FPS_OFF_TIME0) >> 2)]);
    end else if (rd_addr == `FPS_OFF_STATUS) begin
      rd_data[`FPS_ST_OUT] = out_r;
      rd_data[`FPS_ST_ACT_LSB +: 5] = act;
      rd_data[`FPS_ST_KEY] = unlock_key;
      rd_data[`FPS_ST_CH_LSB +: CH_W] = ch_r;
    end else if (rd_addr[1:0] == 2'b00 &&
                 in_range(rd_addr, `FPS_OFF_SW0, NUM_CH)) begin
      rd_data = 32'(switch_angle_r[CH_W'(8'(rd_addr - `FPS_OFF_SW0) >> 2)]);
    end else begin
      rd_err = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_locked;
    !unlock_key |=> !pulse_train_out;
  endproperty
  a_locked: assert property (p_locked)
    else $error("output high without unlock key");

  property p_primary_off;
    !ctrl_r[`FPS_BIT_PRIMARY] |=> !pulse_train_out;
  endproperty
  a_primary_off: assert property (p_primary_off)
    else $error("output high with primary gate off");

  property p_fifth_blocked;
    !ctrl_r[`FPS_BIT_FOURTH] |-> !start[4] && !start[3];
  endproperty
  a_fifth_blocked: assert property (p_fifth_blocked)
    else $error("late pulse started with fourth gate off");

  property p_strobe_once;
    channel_switch_strobe |=> !channel_switch_strobe;
  endproperty
  a_strobe_once: assert property (p_strobe_once)
    else $error("switch strobe longer than one clock");

  property p_switch_step;
    switch_hit |=> channel_switch_strobe &&
      active_channel != $past(active_channel);
  endproperty
  a_switch_step: assert property (p_switch_step)
    else $error("switch angle did not advance the channel");

  property p_main_rise;
    (start[2] && !act[2] && !switch_hit && unlock_key &&
     len[2] != `FPS_TIME_RST && !done[2]) |=> act[2] ##1 pulse_train_out;
  endproperty
  a_main_rise: assert property (p_main_rise)
    else $error("main pulse did not rise at start angle");

  property p_or_out;
    (unlock_key && |(act & allow)) |=> pulse_train_out;
  endproperty
  a_or_out: assert property (p_or_out)
    else $error("active enabled pulse not on output");

  c_main: cover property (start[2] ##[1:20] pulse_train_out);
  c_fifth: cover property (start[4] ##[1:200] act[4]);
  c_switch: cover property (channel_switch_strobe);

endmodule
`default_nettype wire

// [verif/fps_crank_model.sv]
// Crank position and unlock key source standing in for the tracker.
`timescale 1ns/1ps
`default_nettype none

module fps_crank_model #(
  parameter int STEP = 16,
  parameter int CYCLE = 128
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic key_req,
  output logic [15:0] crank_angle,
  output logic unlock_key
);
  int div_r;

  // ----------------------------------------------------------------------
  // Crank position
  // ----------------------------------------------------------------------
  // The angle steps once every STEP clocks and wraps at the cycle end.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 0;
      crank_angle <= 16'h0000;
    end else if (div_r == STEP - 1) begin
      div_r <= 0;
      if (crank_angle == 16'(CYCLE - 1)) begin
        crank_angle <= 16'h0000;
      end else begin
        crank_angle <= crank_angle + 16'h0001;
      end
    end else begin
      div_r <= div_r + 1;
    end
  end

  // ----------------------------------------------------------------------
  // Unlock key
  // ----------------------------------------------------------------------
  // Exactly one register stage, as the integrator must supply it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlock_key <= 1'b0;
    end else begin
      unlock_key <= key_req;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the five-pulse fuel sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, rstn, key_req, unlock_key, pulse_train_out, channel_switch_strobe;
  logic [15:0] crank_angle;
  logic [1:0] active_channel, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int mismatches = 0;
  int checked = 0;
  logic [23:0] tv [7] = '{24'h3, 24'h5, 24'h7, 24'h4, 24'hB, 24'h2, 24'hD};
  logic [4:0] ctl [9] = '{5'h00, 5'h1E, 5'h01, 5'h03, 5'h05, 5'h09, 5'h19,
                          5'h11, 5'h1F};
  logic [31:0] exph [9] = '{0, 0, 3, 8, 10, 14, 27, 3, 39};

  fps_crank_model PM (.clk(clk), .rstn(rstn), .key_req(key_req),
    .crank_angle(crank_angle), .unlock_key(unlock_key));
  fps_sequencer DUT (.clk(clk), .rstn(rstn), .crank_angle(crank_angle),
    .unlock_key(unlock_key), .pulse_train_out(pulse_train_out),
    .channel_switch_strobe(channel_switch_strobe),
    .active_channel(active_channel), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tmo();
    mismatches++;
    end_of_test();
  endtask

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int i;
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 100 && !(aw && w); i++) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100 && s_axi_bvalid !== 1'b1; i++) @(posedge clk);
    if (i == 100 || !(aw && w)) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 100) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One whole engine cycle: high cycles, strobes and channel steps.
  task automatic run_cycle(input logic [31:0] exp_hi);
    int i;
    logic [31:0] hi, sw, chg;
    logic [1:0] ch;
    hi = 0;
    sw = 0;
    chg = 0;
    for (i = 0; i < 4000 && crank_angle !== 16'h0000; i++) @(posedge clk);
    if (i == 4000) tmo();
    ch = active_channel;
    repeat (128 * 16) begin
      @(posedge clk);
      if (pulse_train_out === 1'b1) hi++;
      if (channel_switch_strobe === 1'b1) sw++;
      if (active_channel !== ch) chg++;
      ch = active_channel;
    end
    check("pulse high cycles", hi, exp_hi);
    check("switch strobes", sw, 32'h4);
    check("channel steps", chg, 32'h4);
  endtask

  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int k;
    rstn = 1'b0;
    key_req = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, d, r);
    check("gate reset", d, 32'h0);
    // Bit 24 set in every time word: only the low 24 bits may count.
    for (k = 0; k < 7; k++) wr(8'(8'h10 + 4 * k), {8'h01, tv[k]}, r);
    wr(8'h04, 32'h00000014, r);
    wr(8'h08, 32'h0000000A, r);
    wr(8'h0C, 32'h00000005, r);
    // Switch angles ascend and sit well past the start angle.
    for (k = 0; k < 4; k++) begin
      wr(8'(8'h30 + 4 * k), 100 + 8 * k, r);
    end
    rd(8'h10, d, r);
    check("primary length", d, 32'h3);
    rd(8'h80, d, r);
    check("unmapped read", {30'h0, r}, 32'h2);
    wr(8'h2C, 32'h00000001, r);
    check("status write resp", {30'h0, r}, 32'h2);
    $display("register test done");
    for (k = 0; k < 9; k++) begin
      wr(8'h00, {27'h0, ctl[k]}, r);
      check("gate write resp", {30'h0, r}, 32'h0);
      run_cycle(exph[k]);
      $display("gate test %0d done", k);
    end
    key_req <= 1'b0;
    run_cycle(32'h0);
    $display("locked output test done");
    end_of_test();
  end
endmodule
`default_nettype wire
